/* File: rst_ctrl_pkg.sv */
package rst_ctrl_pkg;

  localparam logic [7:0] UNIT_RESET_CONTROL_ADDR = 8'h82;
  localparam logic [7:0] RESET_INTERRUPT_CLEAR_ADDR = 8'h84;
  localparam logic [7:0] UNIT_RESET_CONTROL_RST = 8'h00;
  localparam logic [7:0] UNIT_RESET_CONTROL_MASK = 8'h1b;
  localparam int GPIO_BIT = 0;
  localparam int KEYPAD_BIT = 1;
  localparam int PWM_BIT = 3;
  localparam int INTC_BIT = 4;
  localparam int CLEAR_FLAG_BIT = 0;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam int POR_FLAG_POS = 0;

  typedef struct packed {
    logic intc;
    logic pwm;
    logic keypad;
    logic gpio;
  } unit_resets_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    ST_IN_RESET = 2'b00,
    ST_RUN = 2'b01
  } run_state_t;

endpackage

/* File: intc_status.sv */
`timescale 1ns/10ps
`default_nettype none
module intc_status
  import rst_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic intc_reset_i,
  input wire logic [7:0] event_i,
  input wire logic [7:0] clear_i,
  output logic [7:0] status_o,
  output logic [7:0] visible_o
);

  logic [7:0] status_q;

  // Collection keeps running under unit reset; set beats clear
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          status_q[g] <= STATUS_RST[g];
        end else if (ce_i) begin
          if (event_i[g]) begin
            status_q[g] <= 1'b1;
          end else if (clear_i[g]) begin
            status_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign status_o = status_q;
  assign visible_o = intc_reset_i ? STATUS_RST : status_q;

  property p_hide_under_reset;
    @(posedge sys_clk_i) disable iff (rst_i)
    intc_reset_i |-> visible_o == 8'h00;
  endproperty
  a_hide_under_reset: assert property (p_hide_under_reset)
    else $error("status visible under intc reset");

  // Events arriving under unit reset must still land in the status
  property p_pending_kept;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && intc_reset_i |=> (status_o & $past(event_i)) == $past(event_i);
  endproperty
  a_pending_kept: assert property (p_pending_kept)
    else $error("pending event lost during intc reset");

endmodule
`default_nettype wire

/* File: block_reset_control.sv */
`timescale 1ns/10ps
`default_nettype none
module block_reset_control
  import rst_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sw_reset_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] irq_event_i,
  input wire logic [7:0] irq_clear_i,
  input wire logic irq_pin_request_i,
  output logic [7:0] reg_rdata_o,
  output logic intc_unit_reset_o,
  output logic pwm_timers_unit_reset_o,
  output logic keypad_unit_reset_o,
  output logic gpio_unit_reset_o,
  output logic [7:0] interrupt_status_reg_o,
  output logic interrupt_request_pin_o
);

  reg_req_t req;
  logic [7:0] unit_reset_control_q;
  unit_resets_t resets;
  run_state_t state_q;
  logic sw_reset_meta_q;
  logic sw_reset_sync_q;
  logic por_event;
  logic flag_clear;
  logic [7:0] events;
  logic [7:0] clears;
  logic [7:0] status_raw;
  logic [7:0] status_vis;
  logic [7:0] reg_rdata_q;
  logic [7:0] irq_status_q;
  logic irq_pin_q;
  logic [3:0] unit_q;

  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                 wdata: reg_wdata_i};

  // Software reset arrives from the pin domain
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sw_reset_meta_q <= 1'b0;
      sw_reset_sync_q <= 1'b0;
    end else if (ce_i) begin
      sw_reset_meta_q <= sw_reset_i;
      sw_reset_sync_q <= sw_reset_meta_q;
    end
  end

  // Unit reset bits: only host writes and hardware or software reset change them
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || (ce_i && sw_reset_sync_q)) begin
      unit_reset_control_q <= UNIT_RESET_CONTROL_RST;
    end else if (ce_i && req.wr && req.addr == UNIT_RESET_CONTROL_ADDR) begin
      unit_reset_control_q <= req.wdata & UNIT_RESET_CONTROL_MASK;
    end
  end

  assign resets = '{intc: unit_reset_control_q[INTC_BIT],
                    pwm: unit_reset_control_q[PWM_BIT],
                    keypad: unit_reset_control_q[KEYPAD_BIT],
                    gpio: unit_reset_control_q[GPIO_BIT]};

  // Leaving hardware or software reset raises the power-on flag once
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || (ce_i && sw_reset_sync_q)) begin
      state_q <= ST_IN_RESET;
    end else if (ce_i) begin
      state_q <= ST_RUN;
    end
  end

  assign por_event = state_q == ST_IN_RESET;
  assign flag_clear = req.wr && req.addr == RESET_INTERRUPT_CLEAR_ADDR &&
                      req.wdata[CLEAR_FLAG_BIT];

  always_comb begin
    events = irq_event_i;
    clears = irq_clear_i;
    events[POR_FLAG_POS] = por_event;
    clears[POR_FLAG_POS] = flag_clear;
  end

  intc_status u_intc_status (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .intc_reset_i(resets.intc),
    .event_i(events),
    .clear_i(clears),
    .status_o(status_raw),
    .visible_o(status_vis)
  );

  // Read data; write-only clear register reads zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reg_rdata_q <= 8'h00;
    end else if (ce_i && req.rd) begin
      case (req.addr)
        UNIT_RESET_CONTROL_ADDR: reg_rdata_q <= unit_reset_control_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Unit reset outputs, one cycle behind the control bits; intc only masks its status view
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      unit_q <= 4'h0;
    end else if (ce_i) begin
      unit_q <= resets;
    end
  end

  // Status view seen by the host; masked under interrupt reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_status_q <= STATUS_RST;
    end else if (ce_i) begin
      irq_status_q <= status_vis;
    end
  end

  // Pin follows its request independent of interrupt unit reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_pin_q <= 1'b0;
    end else if (ce_i) begin
      irq_pin_q <= irq_pin_request_i;
    end
  end

  assign reg_rdata_o = reg_rdata_q;
  assign intc_unit_reset_o = unit_q[3];
  assign pwm_timers_unit_reset_o = unit_q[2];
  assign keypad_unit_reset_o = unit_q[1];
  assign gpio_unit_reset_o = unit_q[0];
  assign interrupt_status_reg_o = irq_status_q;
  assign interrupt_request_pin_o = irq_pin_q;

  property p_bits_hold;
    @(posedge sys_clk_i) disable iff (rst_i || sw_reset_sync_q)
    !(ce_i && req.wr && req.addr == UNIT_RESET_CONTROL_ADDR)
      |=> $stable(unit_reset_control_q);
  endproperty
  a_bits_hold: assert property (p_bits_hold)
    else $error("unit reset bits changed without a write");

  property p_ctrl_write;
    @(posedge sys_clk_i) disable iff (rst_i || sw_reset_sync_q)
    ce_i && req.wr && req.addr == UNIT_RESET_CONTROL_ADDR
      |=> unit_reset_control_q ==
        ($past(req.wdata) & UNIT_RESET_CONTROL_MASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("unit reset write not applied");

  property p_reserved_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    (unit_reset_control_q & ~UNIT_RESET_CONTROL_MASK) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved unit reset bit set");

  property p_reset_default;
    @(posedge sys_clk_i)
    rst_i |=> unit_reset_control_q == UNIT_RESET_CONTROL_RST;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("unit reset bits not cleared by reset");

  // Software reset also returns the bits to their defaults
  property p_sw_clears;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && sw_reset_sync_q |=> unit_reset_control_q == UNIT_RESET_CONTROL_RST;
  endproperty
  a_sw_clears: assert property (p_sw_clears)
    else $error("unit reset bits not cleared by software reset");

  property p_unit_out;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i |=> intc_unit_reset_o == $past(unit_reset_control_q[INTC_BIT])
      && pwm_timers_unit_reset_o == $past(unit_reset_control_q[PWM_BIT])
      && keypad_unit_reset_o == $past(unit_reset_control_q[KEYPAD_BIT])
      && gpio_unit_reset_o == $past(unit_reset_control_q[GPIO_BIT]);
  endproperty
  a_unit_out: assert property (p_unit_out)
    else $error("unit reset output mismatch");

  property p_status_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && resets.intc |=> interrupt_status_reg_o == 8'h00;
  endproperty
  a_status_zero: assert property (p_status_zero)
    else $error("status not zero under intc reset");

  // Once released, the host sees everything collected meanwhile
  property p_status_view;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && !resets.intc |=> interrupt_status_reg_o == $past(status_raw);
  endproperty
  a_status_view: assert property (p_status_view)
    else $error("status view lags collected status");

  property p_pin_free;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i |=> interrupt_request_pin_o == $past(irq_pin_request_i);
  endproperty
  a_pin_free: assert property (p_pin_free)
    else $error("request pin affected");

  property p_por_set;
    @(posedge sys_clk_i)
    rst_i ##1 !rst_i && ce_i && !sw_reset_sync_q |=> status_raw[POR_FLAG_POS];
  endproperty
  a_por_set: assert property (p_por_set)
    else $error("power-on flag not set after reset");

  // First edge of a software reset only parks the state, so wait one more
  property p_sw_por;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && sw_reset_sync_q ##1 ce_i |=> status_raw[POR_FLAG_POS];
  endproperty
  a_sw_por: assert property (p_sw_por)
    else $error("power-on flag not set after software reset");

  property p_flag_clear;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && flag_clear && !por_event |=> !status_raw[POR_FLAG_POS];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("power-on flag not cleared");

  property p_zero_write;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && status_raw[POR_FLAG_POS] && !flag_clear
      |=> status_raw[POR_FLAG_POS];
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("power-on flag lost");

  property p_hold_status;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && resets.intc && irq_clear_i[2] && !irq_event_i[2]
      |=> !status_raw[2];
  endproperty
  a_hold_status: assert property (p_hold_status)
    else $error("clear ignored under intc reset");

  property p_rdata_ctrl;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && req.rd && req.addr == UNIT_RESET_CONTROL_ADDR
      |=> reg_rdata_o == $past(unit_reset_control_q);
  endproperty
  a_rdata_ctrl: assert property (p_rdata_ctrl)
    else $error("unit reset read mismatch");

  property p_rdata_clr;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && req.rd && req.addr == RESET_INTERRUPT_CLEAR_ADDR
      |=> reg_rdata_o == 8'h00;
  endproperty
  a_rdata_clr: assert property (p_rdata_clr)
    else $error("write-only clear register read nonzero");

  property p_unmapped_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i && req.rd && req.addr != UNIT_RESET_CONTROL_ADDR
      |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read nonzero");

  // Read data stands until the next read so a slow host can fetch it
  property p_rdata_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    !(ce_i && req.rd) |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_freeze;
    @(posedge sys_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(unit_reset_control_q) && $stable(status_raw)
      && $stable(reg_rdata_o);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while clock enable low");

  property p_sync_path;
    @(posedge sys_clk_i) disable iff (rst_i)
    ce_i |=> sw_reset_sync_q == $past(sw_reset_meta_q);
  endproperty
  a_sync_path: assert property (p_sync_path)
    else $error("software reset synchroniser skipped a stage");

endmodule
`default_nettype wire

/* File: host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_model
  import rst_ctrl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic [7:0] rdata_i,
  output var reg_req_t req_o
);
  initial req_o = '0;
  // Single byte, held across one sampling edge; released bus shows inverse
  task automatic access(input logic w, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
    @(negedge sys_clk_i);
    req_o = '{wr: w, rd: !w, addr: a, wdata: d};
    @(negedge sys_clk_i);
    q = rdata_i;
    req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  import rst_ctrl_pkg::*;
  logic sys_clk_i = 0, rst_i = 1, sw_rst = 0, pin_req = 0, ce = 1;
  logic [7:0] ev = 0, clr = 0, rdata, stat, q;
  logic intc_r, pwm_r, kp_r, gp_r, pin;
  reg_req_t req;
  integer seed = 33168, n_fail = 0, checks = 0, m_ctrl = 0, m_stat = 0, i;
  always #10 sys_clk_i = ~sys_clk_i;
  host_model host (.sys_clk_i(sys_clk_i), .rdata_i(rdata), .req_o(req));
  block_reset_control dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .ce_i(ce), .sw_reset_i(sw_rst), .reg_wr_i(req.wr),
    .reg_rd_i(req.rd), .reg_addr_i(req.addr), .reg_wdata_i(req.wdata),
    .irq_event_i(ev), .irq_clear_i(clr), .irq_pin_request_i(pin_req),
    .reg_rdata_o(rdata), .intc_unit_reset_o(intc_r),
    .pwm_timers_unit_reset_o(pwm_r), .keypad_unit_reset_o(kp_r),
    .gpio_unit_reset_o(gp_r), .interrupt_status_reg_o(stat),
    .interrupt_request_pin_o(pin));
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
    if (a == UNIT_RESET_CONTROL_ADDR)
      m_ctrl = d & UNIT_RESET_CONTROL_MASK;
    if (a == RESET_INTERRUPT_CLEAR_ADDR && d[CLEAR_FLAG_BIT])
      m_stat = m_stat & 8'hfe;
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a);
    host.access(1'b0, a, 8'h00, q);
  endtask
  // Bit 0 of event and clear lines is ignored: flag lives inside
  task automatic pulse(input logic [7:0] e, input logic [7:0] c);
    @(negedge sys_clk_i);
    ev = e;
    clr = c;
    @(negedge sys_clk_i);
    ev = 0;
    clr = 0;
    m_stat = (m_stat & ~(c & 8'hfe)) | (e & 8'hfe);
    repeat (2) @(negedge sys_clk_i);
  endtask
  task automatic check_all;
    `CHK("intc", 1'(m_ctrl >> INTC_BIT), intc_r)
    `CHK("pwm", 1'(m_ctrl >> PWM_BIT), pwm_r)
    `CHK("keypad", 1'(m_ctrl >> KEYPAD_BIT), kp_r)
    `CHK("gpio", 1'(m_ctrl >> GPIO_BIT), gp_r)
    `CHK("status", 8'(m_ctrl[INTC_BIT] ? 0 : m_stat), stat)
    `CHK("pin", pin_req, pin)
  endtask
  task automatic hw_reset;
    @(negedge sys_clk_i);
    rst_i = 1;
    repeat (16) @(negedge sys_clk_i);
    rst_i = 0;
    m_ctrl = 0;
    m_stat = 1;
    repeat (4) @(negedge sys_clk_i);
    check_all();
  endtask
  initial begin
    #200000;
    n_fail++;
    give_verdict();
  end
  initial begin
    hw_reset();
    rd(UNIT_RESET_CONTROL_ADDR);
    `CHK("ctrl_rst", UNIT_RESET_CONTROL_RST, q)
    $display("reset test end");
    // Random control values mixed with random events and clears
    for (i = 0; i < 16; i++) begin
      pin_req = 1'($random(seed));
      wr(UNIT_RESET_CONTROL_ADDR, 8'($random(seed)));
      pulse(8'($random(seed)), 8'($random(seed)));
      check_all();
      rd(UNIT_RESET_CONTROL_ADDR);
      `CHK("ctrl", 8'(m_ctrl), q)
    end
    $display("random test end");
    wr(UNIT_RESET_CONTROL_ADDR, 8'h00);
    pulse(8'h00, 8'hfe);
    wr(UNIT_RESET_CONTROL_ADDR, 8'h10);
    pulse(8'h24, 8'h00);
    check_all();
    rd(UNIT_RESET_CONTROL_ADDR);
    `CHK("ctrl_held", 8'h10, q)
    pulse(8'h00, 8'h04);
    wr(UNIT_RESET_CONTROL_ADDR, 8'h00);
    check_all();
    $display("pending test end");
    wr(RESET_INTERRUPT_CLEAR_ADDR, 8'hfe);
    check_all();
    wr(RESET_INTERRUPT_CLEAR_ADDR, 8'h01);
    check_all();
    rd(RESET_INTERRUPT_CLEAR_ADDR);
    `CHK("clr_rd", 8'h00, q)
    rd(8'h90);
    `CHK("unmapped", 8'h00, q)
    $display("flag test end");
    // Clock enable low: events are ignored and all state holds
    @(negedge sys_clk_i);
    ce = 0;
    ev = 8'h80;
    repeat (3) @(negedge sys_clk_i);
    ev = 0;
    check_all();
    ce = 1;
    repeat (2) @(negedge sys_clk_i);
    check_all();
    $display("freeze test end");
    pulse(8'h00, 8'hfe);
    wr(UNIT_RESET_CONTROL_ADDR, 8'hff);
    check_all();
    @(negedge sys_clk_i);
    sw_rst = 1;
    repeat (4) @(negedge sys_clk_i);
    sw_rst = 0;
    m_ctrl = 0;
    m_stat = m_stat | 1;
    repeat (6) @(negedge sys_clk_i);
    check_all();
    wr(RESET_INTERRUPT_CLEAR_ADDR, 8'h01);
    hw_reset();
    $display("reset source test end");
    give_verdict();
  end
endmodule
`default_nettype wire
